/* File: src/occ_pkg.sv */
// package: register map, field layout and encodings for the oscillator control block
package occ_pkg;
    // register byte addresses (word aligned)
    localparam logic [3:0] OCC_ADDR_CTRL  = 4'h0;
    localparam logic [3:0] OCC_ADDR_CTRL2 = 4'h4;
    localparam logic [3:0] OCC_ADDR_TUNE  = 4'h8;
    localparam logic [3:0] OCC_ADDR_STAT  = 4'hc;
    // main control field positions
    localparam int OCC_IDLE_BIT  = 7;
    localparam int OCC_INTERNAL_FREQ_SELECT_LSB  = 4;
    localparam int OCC_STARTUP_TIMER_DONE_FLAG_BIT  = 3;
    localparam int OCC_HFS_BIT   = 2;
    localparam int OCC_SCS_LSB   = 0;
    // second control field positions
    localparam int OCC_SRUN_BIT  = 6;
    localparam int OCC_SDRV_BIT  = 4;
    localparam int OCC_SGO_BIT   = 3;
    localparam int OCC_MFS_BIT   = 1;
    localparam int OCC_MSEL_BIT  = 0;
    // tuning field positions
    localparam int OCC_LSRC_BIT  = 7;
    localparam int OCC_PLL_BIT   = 6;
    // reset values
    localparam logic [2:0] OCC_INTERNAL_FREQ_SELECT_RST = 3'h6;
    localparam logic [1:0] OCC_SCS_RST  = 2'h0;
    localparam logic       OCC_SDRV_RST = 1'b1;
    // frequency select codes
    localparam logic [2:0] OCC_F16M  = 3'h7;
    localparam logic [2:0] OCC_F8M   = 3'h6;
    localparam logic [2:0] OCC_F4M   = 3'h5;
    localparam logic [2:0] OCC_F2M   = 3'h4;
    localparam logic [2:0] OCC_F1M   = 3'h3;
    localparam logic [2:0] OCC_F500K = 3'h2;
    localparam logic [2:0] OCC_F250K = 3'h1;
    // secondary mode config: digital clock input
    localparam logic [1:0] OCC_SMODE_DIG = 2'h2;
    // clock source choice
    typedef enum logic [1:0] {
        OCC_SRC_PRI = 2'b00,
        OCC_SRC_SEC = 2'b01,
        OCC_SRC_INT = 2'b11
    } occ_src_t;
    // internal clock path choice (binary, fed to divider/mux)
    typedef enum logic [3:0] {
        OCC_P_HF1 = 4'h0, OCC_P_HF2 = 4'h1, OCC_P_HF4 = 4'h2, OCC_P_HF8 = 4'h3,
        OCC_P_HF16 = 4'h4, OCC_P_HF32 = 4'h5, OCC_P_HF64 = 4'h6, OCC_P_HF512 = 4'h7,
        OCC_P_MF1 = 4'h8, OCC_P_MF2 = 4'h9, OCC_P_MF16 = 4'ha, OCC_P_LF = 4'hb
    } occ_path_t;
    // switch sequencer states, gray along the path
    typedef enum logic [1:0] {
        OCC_SW_IDLE = 2'b00,
        OCC_SW_OLD  = 2'b01,
        OCC_SW_NEW  = 2'b11
    } occ_sw_t;
    // glitch-free pause lengths in cycles of old and new source
    localparam logic [2:0] OCC_OLD_CYC = 3'h2;
    localparam logic [2:0] OCC_NEW_CYC = 3'h4;
endpackage

/* File: src/occ_top.sv */
// oscillator control registers with Avalon-MM slave and clock source selection logic
// Behaviour
// - sleep enters idle if idle bit set
// - codes 111..011 pick fast oscillator divisions
// - substitute off: 010/001/000 fast dividers or slow
// - substitute on: medium oscillator paths or slow
// - frequency select write switches immediately if internal
// - source select: 1x internal, 01 secondary, 00 primary
// - source select write starts immediate switch
// - startup flag: timer done and primary running
// - startup flag set for the first cycle after reset, two-speed config ignored
// - fast oscillator stable flag read-only
// - secondary run flag when secondary clocks system
// - drive bit forces high power, not digital
// - keep-alive bit runs secondary, not digital
// - medium oscillator stable flag read-only
// - substitute gives 500k/250k/31k from medium
// - low-source bit picks fast/512 or slow
// - tuning bit 6 enables multiplier, reset 0
// - trim is signed six-bit, centre zero
// - unimplemented second-control bits read zero
// - reset clears source select to primary
// - multiplier on internal primary only at 4/8/16M
// - switch pauses two old plus new cycles
//
// Chosen here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module occ_top
    import occ_pkg::*;
#(
    parameter int TRIM_W = 6              // trim field width
)
(
    input  wire logic              CLK,
    input  wire logic              RST_B,
    // Avalon-MM slave
    input  wire logic [3:0]        AVS_ADDRESS,
    input  wire logic              AVS_READ,
    input  wire logic              AVS_WRITE,
    input  wire logic [31:0]       AVS_WRITEDATA,
    input  wire logic [3:0]        AVS_BYTEENABLE,
    output logic [31:0]            AVS_READDATA,
    output logic                   AVS_WAITREQUEST,
    // configuration and oscillator status inputs (asynchronous)
    input  wire logic              TWO_SPEED_STARTUP_ENABLE,
    input  wire logic              INT_IS_PRIMARY,
    input  wire logic [1:0]        SECONDARY_MODE_CONFIG,
    input  wire logic              SECONDARY_REQUEST,
    input  wire logic              STARTUP_TIMER_DONE,
    input  wire logic              FAST_STABLE,
    input  wire logic              MEDIUM_STABLE,
    input  wire logic              SECONDARY_READY,
    input  wire logic              SLEEP_EXEC,
    input  wire logic              OLD_CLK_TICK,
    input  wire logic              NEW_CLK_TICK,
    // control outputs
    output logic                   IDLE_MODE,
    output logic                   SLEEP_MODE,
    output logic [1:0]             CLOCK_SOURCE,
    output logic [3:0]             INTERNAL_PATH,
    output logic                   CLOCK_GATE,
    output logic                   SECONDARY_ENABLE,
    output logic                   SECONDARY_HIGH_POWER,
    output logic                   MULTIPLIER_ON,
    output logic [TRIM_W-1:0]      FAST_RC_TRIM
);

    localparam int NSYNC = 9;             // synchronised inputs

    // whole state of the block
    typedef struct packed {
        logic [NSYNC-1:0] s1;             // sync stage 1
        logic [NSYNC-1:0] s2;             // sync stage 2
        logic [NSYNC-1:0] s3;             // sync stage 3
        logic [NSYNC-1:0] filt;           // agreed input values
        logic             cfg_ok;         // set on first cycle after release
        logic             idle_sel;       // idle_on_sleep_select
        logic [2:0]       ifs;            // internal_freq_select
        logic [1:0]       system_clock_source_select;            // system_clock_source_select
        logic             startup_timer_done_flag;           // startup_timer_done_flag
        logic             sdrv;           // secondary_drive_force_high
        logic             sgo;            // secondary_keep_alive
        logic             msel;           // medium_oscillator_substitute
        logic             lsrc;           // low_freq_source_select
        logic             pll;            // multiplier_loop_enable
        logic [TRIM_W-1:0] trim;          // fast_rc_trim
        occ_sw_t          sw;             // switch sequencer
        logic [2:0]       cnt;            // pause counter
        logic [1:0]       src;            // active source
        logic [3:0]       path;           // active internal path
        logic             gate;           // device clock enable
        logic             idle_o;
        logic             sleep_o;
        logic             sen;
        logic             shp;
        logic             mul;
        logic [31:0]      rdata;
        logic             wait_o;
    } occ_state_t;

    occ_state_t st_reg;                   // registered state
    occ_state_t st_next;                  // next state

    logic [NSYNC-1:0] raw;                // inputs gathered for sync
    logic [NSYNC-1:0] f;                  // filtered view
    logic             acc;                // access accepted this cycle
    logic [7:0]       ctrl_rd;            // read views
    logic [7:0]       ctrl2_rd;
    logic [7:0]       tune_rd;
    logic             sec_dig;            // secondary in digital input mode
    occ_path_t        want_path;          // decoded internal path

    assign raw = {NEW_CLK_TICK, OLD_CLK_TICK, SLEEP_EXEC, SECONDARY_READY,
                  MEDIUM_STABLE, FAST_STABLE, STARTUP_TIMER_DONE,
                  SECONDARY_REQUEST, TWO_SPEED_STARTUP_ENABLE};
    assign f       = st_reg.filt;
    assign sec_dig = (SECONDARY_MODE_CONFIG == OCC_SMODE_DIG);

    // decode of the frequency select into a divider path
    always_comb
    begin
        case (st_reg.ifs)
            OCC_F16M:  want_path = OCC_P_HF1;
            OCC_F8M:   want_path = OCC_P_HF2;
            OCC_F4M:   want_path = OCC_P_HF4;
            OCC_F2M:   want_path = OCC_P_HF8;
            OCC_F1M:   want_path = OCC_P_HF16;
            OCC_F500K: want_path = st_reg.msel ? OCC_P_MF1 : OCC_P_HF32;
            OCC_F250K: want_path = st_reg.msel ? OCC_P_MF2 : OCC_P_HF64;
            default:
            begin
                // slowest setting: dedicated slow oscillator or a divided one
                if (!st_reg.lsrc)
                    want_path = OCC_P_LF;
                else if (st_reg.msel)
                    want_path = OCC_P_MF16;
                else
                    want_path = OCC_P_HF512;
            end
        endcase
    end

    // register read views; status bits come from hardware only
    always_comb
    begin
        ctrl_rd = 8'h00;
        ctrl_rd[OCC_IDLE_BIT]               = st_reg.idle_sel;
        ctrl_rd[OCC_INTERNAL_FREQ_SELECT_LSB +: 3]          = st_reg.ifs;
        ctrl_rd[OCC_STARTUP_TIMER_DONE_FLAG_BIT]               = st_reg.startup_timer_done_flag;
        ctrl_rd[OCC_HFS_BIT]                = f[3];
        ctrl_rd[OCC_SCS_LSB +: 2]           = st_reg.system_clock_source_select;
        ctrl2_rd = 8'h00;
        ctrl2_rd[OCC_SRUN_BIT] = (st_reg.src == OCC_SRC_SEC) && !st_reg.gate ? 1'b0
                                 : (st_reg.src == OCC_SRC_SEC);
        ctrl2_rd[OCC_SDRV_BIT] = st_reg.sdrv;
        ctrl2_rd[OCC_SGO_BIT]  = st_reg.sgo;
        ctrl2_rd[OCC_MFS_BIT]  = f[4];
        ctrl2_rd[OCC_MSEL_BIT] = st_reg.msel;
        tune_rd = {st_reg.lsrc, st_reg.pll, st_reg.trim};
    end

    assign acc = (AVS_READ || AVS_WRITE) && st_reg.wait_o;

    // next-state logic
    always_comb
    begin
        st_next = st_reg;
        // three-stage sync, change taken when stages 2 and 3 agree
        st_next.s1 = raw;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < NSYNC; i++)
        begin
            if (st_reg.s2[i] == st_reg.s3[i])
                st_next.filt[i] = st_reg.s3[i];
        end

        // strap stage 3 read once after reset release, while it still holds zero
        if (!st_reg.cfg_ok)
        begin
            st_next.cfg_ok = (st_reg.s2[0] == st_reg.s3[0]);
            st_next.startup_timer_done_flag   = st_reg.s3[0] ? 1'b0 : 1'b1;
        end
        else
            st_next.startup_timer_done_flag = f[2] && (st_reg.src == OCC_SRC_PRI)
                           && st_reg.gate;

        // bus: one wait cycle, answer on the second
        st_next.wait_o = 1'b1;
        if (acc)
        begin
            st_next.wait_o = 1'b0;
            st_next.rdata  = 32'h0000_0000;
            if (AVS_ADDRESS == OCC_ADDR_CTRL)
            begin
                st_next.rdata[7:0] = ctrl_rd;
                if (AVS_WRITE && AVS_BYTEENABLE[0])
                begin
                    // startup_timer_done_flag and stable bits are not writable
                    st_next.idle_sel = AVS_WRITEDATA[OCC_IDLE_BIT];
                    st_next.ifs      = AVS_WRITEDATA[OCC_INTERNAL_FREQ_SELECT_LSB +: 3];
                    st_next.system_clock_source_select      = AVS_WRITEDATA[OCC_SCS_LSB +: 2];
                end
            end
            else if (AVS_ADDRESS == OCC_ADDR_CTRL2)
            begin
                st_next.rdata[7:0] = ctrl2_rd;
                if (AVS_WRITE && AVS_BYTEENABLE[0])
                begin
                    st_next.sdrv = AVS_WRITEDATA[OCC_SDRV_BIT];
                    st_next.sgo  = AVS_WRITEDATA[OCC_SGO_BIT];
                    st_next.msel = AVS_WRITEDATA[OCC_MSEL_BIT];
                end
            end
            else if (AVS_ADDRESS == OCC_ADDR_TUNE)
            begin
                st_next.rdata[7:0] = tune_rd;
                if (AVS_WRITE && AVS_BYTEENABLE[0])
                begin
                    st_next.lsrc = AVS_WRITEDATA[OCC_LSRC_BIT];
                    st_next.pll  = AVS_WRITEDATA[OCC_PLL_BIT];
                    st_next.trim = AVS_WRITEDATA[TRIM_W-1:0];
                end
            end
            else if (AVS_ADDRESS == OCC_ADDR_STAT)
                st_next.rdata[3:0] = {st_reg.gate, st_reg.sw == OCC_SW_IDLE,
                                      st_reg.src};
            // unmapped addresses read zero, writes dropped
        end

        // internal divider changes at once while internal clocks device
        if (st_reg.src == OCC_SRC_INT || (st_reg.src == OCC_SRC_PRI && INT_IS_PRIMARY))
            st_next.path = want_path;

        // glitch-free source switch sequencer
        case (st_reg.sw)
            OCC_SW_IDLE:
            begin
                if (st_reg.system_clock_source_select[1] ? (st_reg.src != OCC_SRC_INT)
                                  : (st_reg.src != {1'b0, st_reg.system_clock_source_select[0]}))
                begin
                    st_next.sw   = OCC_SW_OLD;
                    st_next.cnt  = 3'h0;
                    st_next.gate = 1'b0;
                end
            end
            OCC_SW_OLD:
            begin
                // two edges of the outgoing clock
                if (f[7])
                    st_next.cnt = st_reg.cnt + 3'h1;
                if (st_reg.cnt == OCC_OLD_CYC)
                begin
                    st_next.sw  = OCC_SW_NEW;
                    st_next.cnt = 3'h0;
                    st_next.src = st_reg.system_clock_source_select[1] ? OCC_SRC_INT
                                                : {1'b0, st_reg.system_clock_source_select[0]};
                end
            end
            OCC_SW_NEW:
            begin
                // new source ticks counted; a secondary source only once ready
                if (f[8] && (st_reg.src != OCC_SRC_SEC || f[5]))
                    st_next.cnt = st_reg.cnt + 3'h1;
                if (st_reg.cnt == OCC_NEW_CYC)
                begin
                    st_next.sw   = OCC_SW_IDLE;
                    st_next.gate = 1'b1;
                end
            end
            default:
                st_next.sw = OCC_SW_IDLE;
        endcase

        // sleep instruction outcome
        st_next.idle_o  = f[6] && st_reg.idle_sel;
        st_next.sleep_o = f[6] && !st_reg.idle_sel;

        // secondary oscillator run and drive
        // keep-alive has no say in digital input mode; requests still count
        st_next.sen = (st_reg.sgo && !sec_dig) || f[1]
                      || (st_reg.src == OCC_SRC_SEC);
        st_next.shp = !sec_dig && (st_reg.sdrv || SECONDARY_MODE_CONFIG[0]);

        // multiplier gating for internal primary
        if (INT_IS_PRIMARY)
            st_next.mul = st_reg.pll && (st_reg.ifs == OCC_F16M ||
                          st_reg.ifs == OCC_F8M || st_reg.ifs == OCC_F4M);
        else
            st_next.mul = st_reg.pll;
    end

    // state register; reset clears the source select
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            st_reg        <= '0;
            st_reg.ifs    <= OCC_INTERNAL_FREQ_SELECT_RST;
            st_reg.system_clock_source_select    <= OCC_SCS_RST;
            st_reg.sdrv   <= OCC_SDRV_RST;
            st_reg.sw     <= OCC_SW_IDLE;
            st_reg.src    <= OCC_SRC_PRI;
            st_reg.gate   <= 1'b1;
            st_reg.wait_o <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    // outputs straight from flops
    assign AVS_READDATA         = st_reg.rdata;
    assign AVS_WAITREQUEST      = st_reg.wait_o;
    assign IDLE_MODE            = st_reg.idle_o;
    assign SLEEP_MODE           = st_reg.sleep_o;
    assign CLOCK_SOURCE         = st_reg.src;
    assign INTERNAL_PATH        = st_reg.path;
    assign CLOCK_GATE           = st_reg.gate;
    assign SECONDARY_ENABLE     = st_reg.sen;
    assign SECONDARY_HIGH_POWER = st_reg.shp;
    assign MULTIPLIER_ON        = st_reg.mul;
    assign FAST_RC_TRIM         = st_reg.trim;

endmodule

/* File: tb/occ_properties.sv */
// checker: bus handshake, clock switch pause and mode output properties
`timescale 1ns/1ps
module occ_properties
    import occ_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RST_B,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    input wire logic        IDLE_MODE,
    input wire logic        SLEEP_MODE,
    input wire logic [1:0]  CLOCK_SOURCE,
    input wire logic        CLOCK_GATE
);
    // one clock domain, so one clocking and one disable for all
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    // request seen while the slave still holds wait high
    sequence s_taken;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
    endsequence
    // device clock stops for a source change
    sequence s_pause_start;
        $fell(CLOCK_GATE);
    endsequence

    property p_answer_one;
        s_taken |=> !AVS_WAITREQUEST;
    endproperty
    property p_wait_low_one;
        $fell(AVS_WAITREQUEST) |=> AVS_WAITREQUEST;
    endproperty
    property p_read_upper_zero;
        !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h000000;
    endproperty
    property p_src_code;
        CLOCK_SOURCE != 2'b10;
    endproperty
    property p_src_in_pause;
        $changed(CLOCK_SOURCE) |-> !CLOCK_GATE;
    endproperty
    // two old plus four new cycles at the least
    property p_pause_min;
        s_pause_start |-> !CLOCK_GATE [*6];
    endproperty
    // ticks are always offered, so the pause must end
    property p_pause_end;
        s_pause_start |-> ##[1:60] CLOCK_GATE;
    endproperty
    property p_rst_primary;
        $rose(RST_B) |-> (CLOCK_SOURCE == 2'b00) && CLOCK_GATE;
    endproperty
    property p_mode_excl;
        !(IDLE_MODE && SLEEP_MODE);
    endproperty

    a_answer_one: assert property (p_answer_one)
        else $error("no answer one cycle after a request");
    a_wait_low_one: assert property (p_wait_low_one)
        else $error("wait request low for more than one cycle");
    a_read_upper_zero: assert property (p_read_upper_zero)
        else $error("read data upper bytes not zero");
    a_src_code: assert property (p_src_code)
        else $error("clock source shows an unused code");
    a_src_in_pause: assert property (p_src_in_pause)
        else $error("clock source changed while clock running");
    a_pause_min: assert property (p_pause_min)
        else $error("clock pause too short");
    a_pause_end: assert property (p_pause_end)
        else $error("clock pause never ended");
    a_rst_primary: assert property (p_rst_primary)
        else $error("source not primary after reset");
    a_mode_excl: assert property (p_mode_excl)
        else $error("idle and sleep both active");
endmodule

bind occ_top occ_properties u_occ_properties (.CLK(CLK), .RST_B(RST_B), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .IDLE_MODE(IDLE_MODE), .SLEEP_MODE(SLEEP_MODE), .CLOCK_SOURCE(CLOCK_SOURCE),
    .CLOCK_GATE(CLOCK_GATE));

/* File: tb/testbench.sv */
// testbench: register access, clock switching and control output scenarios
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module testbench
    import occ_pkg::*;
;
    logic        clk, rst_b, rd, wr, strap, int_pri, sreq, tdone, fstab, mstab, slp;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic [1:0]  smode;
    wire  [31:0] rdata;
    wire  [1:0]  src;
    wire  [3:0]  path;
    wire  [5:0]  trim;
    wire         waitreq, idle_m, sleep_m, gate, sen, shp, mul;
    int          mismatches = 0;
    int          checks = 0;
    int          cycles = 0;

    // ticks and ready held high: every switch may finish promptly
    occ_top u_occ_top (.CLK(clk), .RST_B(rst_b), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitreq), .TWO_SPEED_STARTUP_ENABLE(strap), .INT_IS_PRIMARY(int_pri),
        .SECONDARY_MODE_CONFIG(smode), .SECONDARY_REQUEST(sreq), .STARTUP_TIMER_DONE(tdone),
        .FAST_STABLE(fstab), .MEDIUM_STABLE(mstab), .SECONDARY_READY(1'b1), .SLEEP_EXEC(slp),
        .OLD_CLK_TICK(1'b1), .NEW_CLK_TICK(1'b1), .IDLE_MODE(idle_m), .SLEEP_MODE(sleep_m),
        .CLOCK_SOURCE(src), .INTERNAL_PATH(path), .CLOCK_GATE(gate), .SECONDARY_ENABLE(sen),
        .SECONDARY_HIGH_POWER(shp), .MULTIPLIER_ON(mul), .FAST_RC_TRIM(trim));

    // 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // hang guard, far above the few hundred cycles needed
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one avalon access; idle edge first so strobes never toggle twice in a step
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= {24'h000000, d};
        do @(posedge clk); while (waitreq !== 1'b0);
        q = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wrr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string nm);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        `CHK(nm, e, q)
    endtask

    // wait for a source change to complete, bounded
    task automatic wait_src(input logic [1:0] s);
        int k;
        k = 0;
        settle(2);
        while (!(gate === 1'b1 && src === s) && k < 80)
        begin
            @(posedge clk);
            k++;
        end
        `CHK("source", s, src)
    endtask

    task automatic t_reset_values();
        settle(8);
        rdc(OCC_ADDR_CTRL, 8'h6c, "ctrl reset");
        rdc(OCC_ADDR_CTRL2, 8'h12, "ctrl2 reset");
        rdc(OCC_ADDR_TUNE, 8'h00, "tune reset");
        rdc(OCC_ADDR_STAT, 8'h0c, "status reset");
        wrr(4'h2, 8'hff);
        rdc(4'h2, 8'h00, "unmapped");
        `CHK("trim reset", 6'h00, trim)
    endtask

    task automatic t_read_only();
        wrr(OCC_ADDR_CTRL2, 8'hff);
        settle(6);
        rdc(OCC_ADDR_CTRL2, 8'h1b, "ctrl2 ones");
        `CHK("keep alive", 1'b1, sen)
        `CHK("drive", 1'b1, shp)
        wrr(OCC_ADDR_CTRL2, 8'h00);
        settle(6);
        rdc(OCC_ADDR_CTRL2, 8'h02, "ctrl2 zeros");
        `CHK("keep alive off", 1'b0, sen)
        `CHK("drive off", 1'b0, shp)
        sreq <= 1'b1;
        settle(6);
        `CHK("requested", 1'b1, sen)
        sreq <= 1'b0;
        smode <= 2'b10;
        wrr(OCC_ADDR_CTRL2, 8'h18);
        settle(6);
        `CHK("digital keep alive", 1'b0, sen)
        `CHK("digital drive", 1'b0, shp)
        smode <= 2'b01;
        wrr(OCC_ADDR_CTRL2, 8'h00);
        settle(4);
        `CHK("config drive", 1'b1, shp)
        smode <= 2'b00;
        fstab <= 1'b0;
        mstab <= 1'b0;
        settle(6);
        wrr(OCC_ADDR_CTRL, 8'h6c);
        rdc(OCC_ADDR_CTRL, 8'h68, "fast unstable");
        rdc(OCC_ADDR_CTRL2, 8'h00, "medium unstable");
        fstab <= 1'b1;
        mstab <= 1'b1;
        wrr(OCC_ADDR_CTRL2, 8'h10);
    endtask

    task automatic t_sleep();
        wrr(OCC_ADDR_CTRL, 8'he0);
        slp <= 1'b1;
        settle(6);
        `CHK("idle", 1'b1, idle_m)
        slp <= 1'b0;
        wrr(OCC_ADDR_CTRL, 8'h60);
        settle(6);
        slp <= 1'b1;
        settle(6);
        `CHK("sleep", 1'b1, sleep_m)
        slp <= 1'b0;
        settle(6);
    endtask

    task automatic t_paths();
        // select code, substitute, low source, expected path
        logic [8:0] tbl [12] = '{
            9'b111_0_0_0000, 9'b110_0_0_0001, 9'b101_0_0_0010, 9'b100_0_0_0011,
            9'b011_0_0_0100, 9'b010_0_0_0101, 9'b001_0_0_0110,
            9'b000_0_1_0111, 9'b000_0_0_1011,
            9'b010_1_0_1000, 9'b001_1_0_1001, 9'b000_1_1_1010};
        wrr(OCC_ADDR_CTRL, 8'h62);
        wait_src(2'b11);
        foreach (tbl[i])
        begin
            wrr(OCC_ADDR_TUNE, {tbl[i][4], 7'h00});
            wrr(OCC_ADDR_CTRL2, {7'h08, tbl[i][5]});
            wrr(OCC_ADDR_CTRL, {1'b0, tbl[i][8:6], 4'h2});
            settle(4);
            `CHK("path", tbl[i][3:0], path)
        end
        wrr(OCC_ADDR_CTRL2, 8'h10);
        wrr(OCC_ADDR_TUNE, 8'h00);
    endtask

    task automatic t_switch();
        wrr(OCC_ADDR_CTRL, 8'h61);
        wait_src(2'b01);
        `CHK("secondary in use", 1'b1, sen)
        rdc(OCC_ADDR_CTRL2, 8'h52, "run flag");
        rdc(OCC_ADDR_CTRL, 8'h65, "timer flag off");
        wrr(OCC_ADDR_CTRL, 8'h60);
        wait_src(2'b00);
        rdc(OCC_ADDR_CTRL, 8'h6c, "timer flag on");
        rdc(OCC_ADDR_CTRL2, 8'h12, "run flag off");
    endtask

    task automatic t_tune();
        wrr(OCC_ADDR_TUNE, 8'h1f);
        settle(4);
        `CHK("trim max", 6'h1f, trim)
        wrr(OCC_ADDR_TUNE, 8'h20);
        settle(4);
        `CHK("trim min", 6'h20, trim)
        int_pri <= 1'b1;
        wrr(OCC_ADDR_CTRL, 8'h40);
        wrr(OCC_ADDR_TUNE, 8'h40);
        settle(6);
        `CHK("pll at 2m", 1'b0, mul)
        wrr(OCC_ADDR_CTRL, 8'h70);
        settle(6);
        `CHK("pll at 16m", 1'b1, mul)
        int_pri <= 1'b0;
        wrr(OCC_ADDR_CTRL, 8'h40);
        settle(6);
        `CHK("pll external", 1'b1, mul)
        wrr(OCC_ADDR_TUNE, 8'h00);
        settle(4);
        `CHK("pll off", 1'b0, mul)
        wrr(OCC_ADDR_CTRL, 8'h60);
    endtask

    // second reset with two-speed start and timer still running
    task automatic t_strap();
        strap <= 1'b1;
        tdone <= 1'b0;
        rst_b <= 1'b0;
        settle(3);
        rst_b <= 1'b1;
        settle(8);
        rdc(OCC_ADDR_CTRL, 8'h64, "two speed reset");
        tdone <= 1'b1;
        settle(6);
        rdc(OCC_ADDR_CTRL, 8'h6c, "timer expired");
        strap <= 1'b0;
    endtask

    // main sequence
    initial
    begin
        {rst_b, rd, wr, strap, int_pri, sreq, slp} = 7'h00;
        {tdone, fstab, mstab} = 3'b111;
        addr = 4'h0;
        wdata = 32'h00000000;
        smode = 2'b00;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_reset_values();
        t_read_only();
        t_sleep();
        t_paths();
        t_switch();
        t_tune();
        t_strap();
        wrap_up();
    end
endmodule
